/* rtl/fsg_exchange.sv */
// data exchange core of the fieldbus to serial gateway
`timescale 1ns/1ps
module fsg_exchange
  import fsg_pkg::*;
#(
  parameter int OUT_BYTES    = 2,
  parameter int IN_BYTES     = 8,
  parameter int BUF_DEPTH    = BUF_BYTES,
  parameter int CLEAR_CYCLES = CLEAR_HOLD_CYC
) (
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST_N,
  input  wire logic                   OUT_VALID,
  output logic                        OUT_READY,
  input  wire fsg_pkg::fsg_byte_t     OUT_CTRL0,
  input  wire fsg_pkg::fsg_byte_t     OUT_CTRL1,
  input  wire logic [8*OUT_BYTES-1:0] OUT_DATA,
  output fsg_pkg::fsg_byte_t          IN_STAT0,
  output fsg_pkg::fsg_byte_t          IN_STAT1,
  output logic [8*IN_BYTES-1:0]       IN_DATA,
  input  wire logic                   COLLECTIVE,
  input  wire logic [7:0]             TEL_LEN,
  input  wire logic                   RX_VALID,
  output logic                        RX_READY,
  input  wire fsg_pkg::fsg_byte_t     RX_DATA,
  input  wire logic                   RX_LAST,
  output logic                        TX_VALID,
  input  wire logic                   TX_READY,
  output fsg_pkg::fsg_byte_t          TX_DATA,
  output logic                        GATE_ON,
  input  wire logic [3:0]             DEV_SEL,
  input  wire logic [3:0]             ADDR_HUND,
  input  wire logic [3:0]             ADDR_TENS,
  input  wire logic [3:0]             ADDR_ONES,
  output logic [3:0]                  DEV_TYPE,
  output logic [6:0]                  STATION_ADDR,
  output logic                        ADDR_OK
);
  import fsg_pkg::*;

  localparam int PW = $clog2(BUF_DEPTH);
  localparam int OW = (OUT_BYTES > 1) ? $clog2(OUT_BYTES) : 1;
  localparam int IW = (IN_BYTES > 1) ? $clog2(IN_BYTES) : 1;

  // captured output image of the last accepted exchange
  fsg_byte_t          c0_q;
  fsg_byte_t          c1_q;
  logic [8*OUT_BYTES-1:0] dat_q;
  fsg_byte_t          dat_b [OUT_BYTES];
  // transmit side
  fsg_tx_st_t         st_q;
  logic [PW:0]        idx_q;
  logic [PW:0]        tw_q;
  logic [PW:0]        tr_q;
  fsg_byte_t          tbuf_q [BUF_DEPTH];
  fsg_byte_t          cmd_ch_q;
  logic               send_after_q;
  logic               src_valid;
  fsg_byte_t          src_byte;
  logic               f_in_ready;
  logic               push;
  logic [PW:0]        dlen;
  // receive side
  fsg_byte_t          rbuf_q [BUF_DEPTH];
  logic [PW-1:0]      rw_q;
  logic [PW-1:0]      rr_q;
  logic [PW:0]        rcnt_q;
  logic               rx_push;
  logic               eot_q;
  logic               ld_busy_q;
  logic [PW:0]        ld_idx_q;
  logic [PW:0]        ld_n_q;
  logic [PW:0]        blk_n;
  fsg_byte_t          img_q [IN_BYTES];
  logic               blr_q;
  logic               pend_q;
  fsg_byte_t          vcnt_q;
  logic               ld_go;
  logic               erase;
  // exchange events
  logic               take;
  logic               cmd_on;
  logic               rack_chg;
  logic               ctb_chg;
  logic               sfb_chg;
  logic               data_chg;
  logic               gate_chg;
  logic               ver_rise;
  // clear pattern and startup capture
  logic [31:0]        clr_cnt_q;
  logic               pat;
  logic               clr_hit;
  logic               started_q;
  logic [6:0]         addr_w;
  logic               addr_ok_w;
  fsg_byte_t          stat0;

  // byte view of the captured output data, and the input image laid out on IN_DATA
  genvar gi;
  generate
    for (gi = 0; gi < OUT_BYTES; gi++) begin : g_dat
      assign dat_b[gi] = dat_q[8*gi +: 8];
    end
    for (gi = 0; gi < IN_BYTES; gi++) begin : g_img
      assign IN_DATA[8*gi +: 8] = img_q[gi];
    end
  endgenerate

  // an exchange is held off while a block load or a serial send is still running
  assign OUT_READY = (st_q == TX_IDLE) && !ld_busy_q;
  assign take      = OUT_VALID && OUT_READY;
  // hand-held devices take no commands, so command mode is ignored for them
  assign cmd_on    = OUT_CTRL0[C0_CMD_BIT] && (DEV_TYPE != DEV_HANDHELD);
  assign rack_chg  = take && (OUT_CTRL1[C1_RACK_BIT] ^ c1_q[C1_RACK_BIT]);
  assign ctb_chg   = take && (OUT_CTRL1[C1_CTB_BIT] ^ c1_q[C1_CTB_BIT]);
  assign sfb_chg   = take && (OUT_CTRL1[C1_SFB_BIT] ^ c1_q[C1_SFB_BIT]);
  assign data_chg  = take && (OUT_DATA != dat_q);
  assign gate_chg  = take && cmd_on && (OUT_DATA[CMD_GATE_BIT] ^ dat_q[CMD_GATE_BIT]);
  assign ver_rise  = take && cmd_on && OUT_DATA[CMD_VER_BIT] && !dat_q[CMD_VER_BIT];

  // output image register, previous values feed the toggle compare
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || clr_hit) begin
      c0_q  <= RST_BYTE;
      c1_q  <= RST_BYTE;
      dat_q <= '0;
    end else if (take) begin
      c0_q  <= OUT_CTRL0;
      c1_q  <= OUT_CTRL1;
      dat_q <= OUT_DATA;
    end
  end

  // clear pattern must stand unbroken; the clear wipes c0_q so it fires only once
  assign pat     = (c0_q == CLR_PAT) && (c1_q == CLR_PAT) && (dat_b[0] == CLR_PAT) && (dat_b[1] == CLR_PAT);
  assign clr_hit = pat && (clr_cnt_q == 32'(CLEAR_CYCLES));
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || !pat) begin
      clr_cnt_q <= '0;
    end else if (clr_cnt_q <= 32'(CLEAR_CYCLES)) begin
      clr_cnt_q <= clr_cnt_q + 1'b1;
    end
  end

  // startup capture of device selection and station address
  fsg_addr_dec u_addr (
    .hund (ADDR_HUND),
    .tens (ADDR_TENS),
    .ones (ADDR_ONES),
    .addr (addr_w),
    .ok   (addr_ok_w)
  );
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      started_q    <= 1'b0;
      DEV_TYPE     <= 4'h0;
      STATION_ADDR <= 7'h00;
      ADDR_OK      <= 1'b0;
    end else if (!started_q) begin
      started_q    <= 1'b1;
      DEV_TYPE     <= DEV_SEL;
      STATION_ADDR <= addr_w;
      ADDR_OK      <= addr_ok_w;
    end
  end

  // telegram length for direct sends, never beyond the output image
  assign dlen = (TEL_LEN < OUT_BYTES) ? (PW+1)'(TEL_LEN) : (PW+1)'(OUT_BYTES);

  // byte offered to the transmit fifo by the current sequencer state
  always_comb begin
    src_valid = 1'b0;
    src_byte  = RST_BYTE;
    unique case (st_q)
      TX_DIRECT: begin
        src_valid = idx_q < dlen;
        src_byte  = dat_b[idx_q[OW-1:0]];
      end
      TX_SEND: begin
        src_valid = tr_q != tw_q;
        src_byte  = tbuf_q[tr_q[PW-1:0]];
      end
      TX_CMD: begin
        src_valid = idx_q < (PW+1)'(CMD_LEN);
        src_byte  = (idx_q[1:0] == 2'd0) ? CH_STX :
                    (idx_q[1:0] == 2'd1) ? cmd_ch_q :
                    (idx_q[1:0] == 2'd2) ? CH_CR : CH_LF;
      end
      default: begin
        src_valid = 1'b0;
      end
    endcase
  end
  assign push = src_valid && f_in_ready;

  // transmit sequencer; one event per exchange, except a copy whose send flag also toggled then sends; command mode forwards no data
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || clr_hit) begin
      st_q         <= TX_IDLE;
      idx_q        <= '0;
      tw_q         <= '0;
      tr_q         <= '0;
      cmd_ch_q     <= RST_BYTE;
      send_after_q <= 1'b0;
    end else begin
      unique case (st_q)
        TX_IDLE: if (take) begin
          idx_q        <= '0;
          send_after_q <= sfb_chg;
          if (cmd_on) begin
            cmd_ch_q <= gate_chg ? (OUT_DATA[CMD_GATE_BIT] ? CH_PLUS : CH_MINUS) : CH_VER;
            if (gate_chg || ver_rise) begin
              st_q <= TX_CMD;
            end
          end else if (ctb_chg) begin
            st_q <= TX_COPY;
          end else if (sfb_chg) begin
            st_q <= TX_SEND;
          end else if (data_chg) begin
            st_q <= TX_DIRECT;
          end
        end
        TX_COPY: begin
          // a full buffer drops further bytes rather than overwrite collected ones
          if (tw_q < (PW+1)'(BUF_DEPTH)) begin
            tw_q <= tw_q + 1'b1;
          end
          idx_q <= idx_q + 1'b1;
          if (idx_q == (PW+1)'(OUT_BYTES - 1)) begin
            st_q  <= send_after_q ? TX_SEND : TX_IDLE;
            idx_q <= '0;
          end
        end
        TX_SEND: begin
          if (!src_valid) begin
            tw_q <= '0;
            tr_q <= '0;
            st_q <= TX_IDLE;
          end else if (push) begin
            tr_q <= tr_q + 1'b1;
          end
        end
        TX_DIRECT, TX_CMD: begin
          if (!src_valid) begin
            st_q <= TX_IDLE;
          end else if (push) begin
            idx_q <= idx_q + 1'b1;
          end
        end
        default: begin
          st_q <= TX_IDLE;
        end
      endcase
    end
  end

  // transmit buffer storage, written in arrival order
  always_ff @(posedge SYS_CLK) begin
    if (st_q == TX_COPY && tw_q < (PW+1)'(BUF_DEPTH)) begin
      tbuf_q[tw_q[PW-1:0]] <= dat_b[idx_q[OW-1:0]];
    end
  end

  // two-entry fifo lets the serial side stall without losing a byte
  fsg_fifo #(
    .W     (8),
    .DEPTH (2)
  ) u_txf (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .in_valid  (src_valid),
    .in_ready  (f_in_ready),
    .in_data   (src_byte),
    .out_valid (TX_VALID),
    .out_ready (TX_READY),
    .out_data  (TX_DATA)
  );

  // reading gate follows the command bit, or plus/minus sent directly
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || clr_hit) begin
      GATE_ON <= 1'b0;
    end else if (take && cmd_on) begin
      GATE_ON <= OUT_DATA[CMD_GATE_BIT];
    end else if (data_chg && !ctb_chg && !sfb_chg) begin
      if (OUT_DATA[7:0] == CH_PLUS) begin
        GATE_ON <= 1'b1;
      end else if (OUT_DATA[7:0] == CH_MINUS) begin
        GATE_ON <= 1'b0;
      end
    end
  end

  // receive buffer fill; ready drops when the kByte is full
  assign RX_READY = rcnt_q < (PW+1)'(BUF_DEPTH);
  assign rx_push  = RX_VALID && RX_READY;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || clr_hit) begin
      rw_q   <= '0;
      rcnt_q <= '0;
    end else begin
      if (rx_push) begin
        rw_q <= rw_q + 1'b1;
      end
      if (rx_push && !ld_busy_q) begin
        rcnt_q <= rcnt_q + 1'b1;
      end else if (!rx_push && ld_busy_q) begin
        rcnt_q <= rcnt_q - 1'b1;
      end
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (rx_push) begin
      rbuf_q[rw_q] <= RX_DATA;
    end
  end

  // end of telegram seen, transparent only; a stale end from collective would split the next reply
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || clr_hit) begin
      eot_q <= 1'b0;
    end else if (rx_push && RX_LAST) begin
      eot_q <= 1'b1;
    end else if (ld_go || COLLECTIVE) begin
      eot_q <= 1'b0;
    end
  end

  // block release: collective waits for read-confirm, transparent passes replies at once
  assign blk_n = (rcnt_q < (PW+1)'(IN_BYTES)) ? rcnt_q : (PW+1)'(IN_BYTES);
  assign ld_go = !ld_busy_q && (rcnt_q != '0) &&
                 (COLLECTIVE ? rack_chg : eot_q);
  assign erase = !ld_busy_q && COLLECTIVE && rack_chg && (rcnt_q == '0);

  // block loader into the input image
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || clr_hit) begin
      ld_busy_q <= 1'b0;
      ld_idx_q  <= '0;
      ld_n_q    <= '0;
      rr_q      <= '0;
      blr_q     <= 1'b0;
      vcnt_q    <= RST_BYTE;
      for (int i = 0; i < IN_BYTES; i++) begin
        img_q[i] <= RST_BYTE;
      end
    end else if (ld_go) begin
      ld_busy_q <= 1'b1;
      ld_idx_q  <= '0;
      ld_n_q    <= blk_n;
      for (int i = 0; i < IN_BYTES; i++) begin
        img_q[i] <= RST_BYTE;
      end
    end else if (erase) begin
      vcnt_q <= RST_BYTE;
      for (int i = 0; i < IN_BYTES; i++) begin
        img_q[i] <= RST_BYTE;
      end
    end else if (ld_busy_q) begin
      img_q[ld_idx_q[IW-1:0]] <= rbuf_q[rr_q];
      rr_q     <= rr_q + 1'b1;
      ld_idx_q <= ld_idx_q + 1'b1;
      if (ld_idx_q == ld_n_q - 1'b1) begin
        ld_busy_q <= 1'b0;
        blr_q     <= ~blr_q;
        vcnt_q    <= 8'(ld_n_q);
      end
    end
  end

  // in collective mode the pending flag reflects the fill count one cycle late
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || clr_hit) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= COLLECTIVE && (rcnt_q != '0);
    end
  end

  // status bytes to the master
  always_comb begin
    stat0              = RST_BYTE;
    stat0[S0_PEND_BIT] = pend_q;
    stat0[S0_BLR_BIT]  = blr_q;
  end
  assign IN_STAT0 = stat0;
  assign IN_STAT1 = vcnt_q;
endmodule : fsg_exchange

/* rtl/fsg_pkg.sv */
// shared constants and types of the fieldbus serial gateway exchange
package fsg_pkg;
  // clock and clear-pattern hold time
  localparam int CLK_MHZ        = 100;
  localparam int CLEAR_HOLD_MS  = 20;
  localparam int CLEAR_HOLD_CYC = CLEAR_HOLD_MS * 1000 * CLK_MHZ;

  // buffer size, one kByte each way
  localparam int BUF_BYTES = 1024;

  // control byte 0 / control byte 1 field positions
  localparam int C0_CMD_BIT  = 0;
  localparam int C1_RACK_BIT = 0;
  localparam int C1_SFB_BIT  = 2;
  localparam int C1_CTB_BIT  = 3;

  // status byte 0 field positions
  localparam int S0_BLR_BIT  = 0;
  localparam int S0_PEND_BIT = 3;

  // command-mode bits within data byte 0 (output byte 2)
  localparam int CMD_VER_BIT  = 0;
  localparam int CMD_GATE_BIT = 1;

  // framing and command characters
  localparam logic [7:0] CH_STX   = 8'h02;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_VER   = 8'h76;
  localparam logic [7:0] CLR_PAT  = 8'hAA;
  localparam int         CMD_LEN  = 4;

  // station address limit and device selection codes
  localparam int         MAX_ADDR     = 126;
  localparam logic [3:0] DEV_HANDHELD = 4'h0;
  localparam logic [7:0] RST_BYTE     = 8'h00;

  typedef logic [7:0] fsg_byte_t;
  typedef enum logic [2:0] {TX_IDLE, TX_COPY, TX_DIRECT, TX_SEND, TX_CMD} fsg_tx_st_t;
endpackage : fsg_pkg

/* rtl/fsg_fifo.sv */
// small fifo with valid/ready on both sides, used ahead of the serial transmitter
`timescale 1ns/1ps
module fsg_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          wr_en;
  logic          rd_en;

  // full and empty come straight from the count, so ready drops as soon as both entries hold
  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign wr_en     = in_valid && in_ready;
  assign rd_en     = out_valid && out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_en) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (rd_en) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (wr_en && !rd_en) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (rd_en && !wr_en) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : fsg_fifo

/* rtl/fsg_addr_dec.sv */
// decimal station address switches to a binary address with range check
`timescale 1ns/1ps
module fsg_addr_dec
  import fsg_pkg::*;
(
  input  wire logic [3:0] hund,
  input  wire logic [3:0] tens,
  input  wire logic [3:0] ones,
  output logic [6:0]      addr,
  output logic            ok
);
  logic [9:0] sum;

  // out-of-range digits or sums above the limit are refused and show address zero
  assign sum  = 10'(hund * 7'd100) + 10'(tens * 4'd10) + 10'(ones);
  assign ok   = (hund <= 4'h9) && (tens <= 4'h9) && (ones <= 4'h9) && (sum <= 10'(MAX_ADDR));
  assign addr = ok ? sum[6:0] : 7'h00;
endmodule : fsg_addr_dec

/* verif/fsg_exchange_sva.sv */
// concurrent checks on the gateway exchange ports
`timescale 1ns/1ps
module fsg_exchange_sva
  import fsg_pkg::*;
#(
  parameter int OUT_BYTES = 2,
  parameter int IN_BYTES  = 8,
  parameter int BUF_DEPTH = 1024
) (
  input wire logic                   SYS_CLK,
  input wire logic                   RST_N,
  input wire logic                   OUT_VALID,
  input wire logic                   OUT_READY,
  input wire fsg_pkg::fsg_byte_t     OUT_CTRL0,
  input wire fsg_pkg::fsg_byte_t     OUT_CTRL1,
  input wire logic [8*OUT_BYTES-1:0] OUT_DATA,
  input wire fsg_pkg::fsg_byte_t     IN_STAT0,
  input wire fsg_pkg::fsg_byte_t     IN_STAT1,
  input wire logic                   COLLECTIVE,
  input wire logic                   RX_VALID,
  input wire logic                   RX_READY,
  input wire logic                   TX_VALID,
  input wire logic                   TX_READY,
  input wire fsg_pkg::fsg_byte_t     TX_DATA,
  input wire logic [3:0]             ADDR_HUND,
  input wire logic [3:0]             ADDR_TENS,
  input wire logic [3:0]             ADDR_ONES,
  input wire logic [6:0]             STATION_ADDR,
  input wire logic                   ADDR_OK
);
  logic                   take;
  logic [7:0]             pc1_q;
  logic [8*OUT_BYTES-1:0] pd_q;
  logic [11:0]            sw_q;
  logic [1:0]             rh_q;
  logic [10:0]            rx_cnt_q;

  assign take = OUT_VALID && OUT_READY;

  // last taken image, the reference for toggle and change detection
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pc1_q <= 8'h00;
      pd_q  <= '0;
    end else if (take) begin
      pc1_q <= OUT_CTRL1;
      pd_q  <= OUT_DATA;
    end
  end

  // switch and reset history; no reset here, startup must stay visible
  always_ff @(posedge SYS_CLK) begin
    sw_q <= {ADDR_HUND, ADDR_TENS, ADDR_ONES};
    rh_q <= {rh_q[0], RST_N};
  end

  // bytes ever taken bound the fill from above, drains ignored on purpose
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) rx_cnt_q <= 11'h000;
    else if (RX_VALID && RX_READY && !rx_cnt_q[10]) rx_cnt_q <= rx_cnt_q + 11'h001;
  end

  // decimal digits to a value, out of range when a digit is not decimal
  function automatic int f_val(input logic [11:0] s);
    if (s[11:8] > 4'h9 || s[7:4] > 4'h9 || s[3:0] > 4'h9) return 999;
    return s[11:8] * 100 + s[7:4] * 10 + s[3:0];
  endfunction : f_val

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_rack_take;
    take && COLLECTIVE && IN_STAT0[S0_PEND_BIT] && (OUT_CTRL1[C1_RACK_BIT] != pc1_q[C1_RACK_BIT]);
  endsequence
  sequence s_load;
    !OUT_READY ##[1:20] $changed(IN_STAT0[S0_BLR_BIT]);
  endsequence
  sequence s_direct_take;
    take && !OUT_CTRL0[C0_CMD_BIT] && OUT_CTRL0 != CLR_PAT && OUT_CTRL1[3:2] == pc1_q[3:2] && OUT_DATA != pd_q;
  endsequence

  property p_rack_load; s_rack_take |=> s_load; endproperty
  property p_direct; s_direct_take |=> !OUT_READY ##[0:8] TX_VALID; endproperty
  property p_stat0_rsvd; (IN_STAT0 & 8'hF6) == 8'h00; endproperty
  property p_stat1_max; IN_STAT1 <= IN_BYTES; endproperty
  property p_tx_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA); endproperty
  property p_rx_room; rx_cnt_q < BUF_DEPTH |-> RX_READY; endproperty
  property p_addr_cap;
    rh_q == 2'b01 |-> ADDR_OK == (f_val(sw_q) <= MAX_ADDR) && STATION_ADDR == (ADDR_OK ? 7'(f_val(sw_q)) : 7'h00);
  endproperty
  property p_cap_stable; rh_q == 2'b11 |-> $stable(STATION_ADDR) && $stable(ADDR_OK); endproperty

  a_rack_load: assert property (p_rack_load)
    else $error("read confirm did not load a block");
  a_direct: assert property (p_direct)
    else $error("changed image was not sent directly");
  a_stat0_rsvd: assert property (p_stat0_rsvd)
    else $error("status byte 0 unused bits set");
  a_stat1_max: assert property (p_stat1_max)
    else $error("valid byte count above image size");
  a_tx_hold: assert property (p_tx_hold)
    else $error("serial byte changed while stalled");
  a_rx_room: assert property (p_rx_room)
    else $error("receive refused before buffer full");
  a_addr_cap: assert property (p_addr_cap)
    else $error("station address capture wrong");
  a_cap_stable: assert property (p_cap_stable)
    else $error("startup capture changed later");
endmodule : fsg_exchange_sva

bind fsg_exchange fsg_exchange_sva #(.OUT_BYTES(OUT_BYTES), .IN_BYTES(IN_BYTES), .BUF_DEPTH(BUF_DEPTH)) i_sva (
  .SYS_CLK, .RST_N, .OUT_VALID, .OUT_READY, .OUT_CTRL0, .OUT_CTRL1, .OUT_DATA, .IN_STAT0, .IN_STAT1,
  .COLLECTIVE, .RX_VALID, .RX_READY, .TX_VALID, .TX_READY, .TX_DATA, .ADDR_HUND, .ADDR_TENS, .ADDR_ONES,
  .STATION_ADDR, .ADDR_OK);

/* verif/fsg_serial_dev.sv */
// model of the serial identification device on the far side
`timescale 1ns/1ps
module fsg_serial_dev (
  input wire logic          clk,
  input wire logic          tx_valid,
  output logic              tx_ready,
  input wire fsg_pkg::fsg_byte_t tx_data,
  output logic              rx_valid,
  input wire logic          rx_ready,
  output fsg_pkg::fsg_byte_t rx_data,
  output logic              rx_last
);
  import fsg_pkg::*;
  fsg_byte_t got[$];

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
  end

  // collect serial bytes, stalling about one cycle in four
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= ($urandom_range(3) != 0);
  end

  // one telegram, held per byte until taken; idle line shows the inverse
  task automatic send_tel(input fsg_byte_t b[$]);
    @(posedge clk);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= b[i];
      rx_last  <= (i == b.size() - 1);
      do @(posedge clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~b[b.size() - 1];
  endtask : send_tel
endmodule : fsg_serial_dev

/* verif/testbench.sv */
// self-checking bench for the gateway exchange core
`timescale 1ns/1ps
module testbench;
  import fsg_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0, out_valid = 1'b0, collective = 1'b1;
  fsg_byte_t   c0 = 8'h00, c1 = 8'h00, st0, st1, rx_data, tx_data;
  logic [15:0] dat = 16'h0000;
  logic [63:0] in_data;
  logic [7:0]  tel_len = 8'h02;
  logic [3:0]  dev_sel = 4'h3, a_h = 4'h1, a_t = 4'h2, a_o = 4'h5, dev_type;
  logic [6:0]  st_addr;
  logic        out_ready, rx_valid, rx_ready, rx_last, tx_valid, tx_ready, gate_on, addr_ok;
  fsg_byte_t   exp_q[$], tel[$];
  int          failures = 0, compares = 0;

  always #5 sys_clk = ~sys_clk;

  fsg_exchange #(.CLEAR_CYCLES(20)) i_fsg_exchange (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_CTRL0(c0),
    .OUT_CTRL1(c1), .OUT_DATA(dat), .IN_STAT0(st0), .IN_STAT1(st1), .IN_DATA(in_data),
    .COLLECTIVE(collective), .TEL_LEN(tel_len), .RX_VALID(rx_valid), .RX_READY(rx_ready),
    .RX_DATA(rx_data), .RX_LAST(rx_last), .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .GATE_ON(gate_on), .DEV_SEL(dev_sel), .ADDR_HUND(a_h), .ADDR_TENS(a_t), .ADDR_ONES(a_o),
    .DEV_TYPE(dev_type), .STATION_ADDR(st_addr), .ADDR_OK(addr_ok));

  fsg_serial_dev i_fsg_serial_dev (.clk(sys_clk), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last));

  task automatic wrap_up();
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic cmp_val(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val

  // waits for the expected serial bytes, then a quiet spell to catch extras
  task automatic cmp_tx();
    for (int i = 0; i < 400 && i_fsg_serial_dev.got.size() < exp_q.size(); i++) @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    cmp_val("tx count", 64'(exp_q.size()), 64'(i_fsg_serial_dev.got.size()));
    foreach (exp_q[i])
      if (i < i_fsg_serial_dev.got.size()) cmp_val("tx byte", exp_q[i], i_fsg_serial_dev.got[i]);
    exp_q.delete();
    i_fsg_serial_dev.got.delete();
  endtask : cmp_tx

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  // one cyclic image, held until the core takes it
  task automatic xchg(input fsg_byte_t a, input fsg_byte_t b, input logic [15:0] v);
    @(posedge sys_clk);
    out_valid <= 1'b1;
    c0        <= a;
    c1        <= b;
    dat       <= v;
    do @(posedge sys_clk); while (out_ready !== 1'b1);
    out_valid <= 1'b0;
  endtask : xchg

  task automatic do_reset(input logic [3:0] h, input logic [3:0] t, input logic [3:0] o);
    rst_n <= 1'b0;
    a_h   <= h;
    a_t   <= t;
    a_o   <= o;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  task automatic push_cmd(input fsg_byte_t ch);
    exp_q.push_back(CH_STX);
    exp_q.push_back(ch);
    exp_q.push_back(CH_CR);
    exp_q.push_back(CH_LF);
  endtask : push_cmd

  // expected capture: ok flag above the seven address bits
  function automatic logic [7:0] f_addr(input int v);
    return (v <= MAX_ADDR) ? {1'b1, 7'(v)} : 8'h00;
  endfunction : f_addr

  // expected input image from telegram bytes, upper bytes zero
  function automatic logic [63:0] f_img(input int first, input int n);
    logic [63:0] v = '0;
    for (int i = 0; i < n; i++) v[8*i +: 8] = tel[first + i];
    return v;
  endfunction : f_img

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end

  initial begin
    logic [15:0] d;
    fsg_byte_t   c1v;
    void'($urandom(32'hEF41));
    c1v = 8'h00;
    do_reset(4'h1, 4'h2, 4'h5);
    cmp_val("ready", 2'b11, {out_ready, rx_ready});
    cmp_val("stat", 16'h0000, {st0, st1});
    cmp_val("addr", f_addr(125), {addr_ok, st_addr});
    cmp_val("device", 4'h3, dev_type);
    a_o <= 4'h9;
    wt(3);
    cmp_val("addr held", f_addr(125), {addr_ok, st_addr});
    // direct images; the last two steer the gate by plus and minus, the last cut to one byte
    for (int k = 0; k < 4; k++) begin
      d = (k < 2) ? ((16'($urandom) & 16'hFFFC) | 16'h0100) : {8'($urandom), (k == 2) ? CH_PLUS : CH_MINUS};
      tel_len <= (k == 3) ? 8'h01 : 8'h02;
      xchg(8'h00, c1v, d);
      exp_q.push_back(d[7:0]);
      if (k < 3) exp_q.push_back(d[15:8]);
      cmp_tx();
      if (k > 1) cmp_val("gate", 64'(k == 2), gate_on);
    end
    // command mode: gate on, version query, gate off; data never forwarded
    for (int k = 0; k < 3; k++) begin
      xchg(8'h01, c1v, {8'($urandom), (k == 0) ? 8'h02 : (k == 1) ? 8'h03 : 8'h00});
      push_cmd((k == 0) ? CH_PLUS : (k == 1) ? CH_VER : CH_MINUS);
      cmp_tx();
      cmp_val("gate", 64'(k < 2), gate_on);
    end
    // framed telegrams collected over n images, then sent in one go
    for (int n = 3; n > 1; n--) begin
      for (int k = 0; k < n; k++) begin
        c1v ^= 8'h08;
        d = (k == 0) ? {8'($urandom), CH_STX} : (k == n - 1) ? {CH_LF, CH_CR} : 16'($urandom);
        xchg(8'h00, c1v, d);
        exp_q.push_back(d[7:0]);
        exp_q.push_back(d[15:8]);
      end
      wt(10);
      cmp_val("tx early", 0, 64'(i_fsg_serial_dev.got.size()));
      c1v ^= 8'h04;
      xchg(8'h00, c1v, d);
      cmp_tx();
    end
    // ten bytes wait for the master, then leave in two blocks
    for (int k = 0; k < 10; k++) tel.push_back(8'($urandom_range(255, 1)));
    i_fsg_serial_dev.send_tel(tel);
    wt(5);
    cmp_val("pending", 8'h08, st0);
    cmp_val("image held", 64'h0, in_data);
    for (int k = 0; k < 3; k++) begin
      c1v ^= 8'h01;
      xchg(8'h00, c1v, d);
      wt(20);
      cmp_val("image", (k == 0) ? f_img(0, 8) : (k == 1) ? f_img(8, 2) : 64'h0, in_data);
      cmp_val("count", (k == 0) ? 8 : (k == 1) ? 2 : 0, st1);
      cmp_val("pending", 64'(k == 0), st0[S0_PEND_BIT]);
      if (k < 2) cmp_val("block toggle", 64'(k == 0), st0[S0_BLR_BIT]);
    end
    // transparent mode hands a reply over unasked
    collective <= 1'b0;
    tel.delete();
    for (int k = 0; k < 3; k++) tel.push_back(8'($urandom_range(255, 1)));
    i_fsg_serial_dev.send_tel(tel);
    wt(20);
    cmp_val("reply", f_img(0, 3), in_data);
    cmp_val("count", 3, st1);
    // clear pattern held past its limit wipes state, not the captures
    xchg(8'h00, c1v, {8'h11, CH_PLUS});
    xchg(CLR_PAT, CLR_PAT, {CLR_PAT, CLR_PAT});
    wt(40);
    cmp_val("cleared", 64'h0, {st0, st1, |in_data, gate_on});
    i_fsg_serial_dev.got.delete();
    do_reset(4'h1, 4'h2, 4'h7);
    cmp_val("addr", f_addr(127), {addr_ok, st_addr});
    wrap_up();
  end
endmodule : testbench
